/* rtl/indirect_addr_pkg.sv */
// Constants, types and decode helpers of the indirect address unit
package indirect_addr_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;             // Data-memory address width
    localparam int DATA_W = 8;              // Data byte width
    localparam int HIGH_W = ADDR_W - DATA_W; // Bits held by a pointer high byte
    localparam int NUM_PTR = 3;             // Number of data pointers

    // ------------------------------------------------------------------
    // Layout of the pointer control page in the register file
    // ------------------------------------------------------------------
    localparam int PAGE_LSB = 6;            // Address bits above this select the page
    localparam int SEL_LSB = 4;             // Pointer select field position
    localparam int SEL_W = 2;               // Pointer select field width
    localparam int OFF_W = 4;               // Register offset field width
    localparam logic [ADDR_W-PAGE_LSB-1:0] CTRL_PAGE = 6'h3f; // Page holding pointer regs

    // Register offsets within one pointer's slot
    typedef enum logic [OFF_W-1:0] {
        OFF_INDIRECT = 4'h0,                // indirect_window
        OFF_POST_DECREMENT_WINDOW = 4'h1,                 // post_decrement_window
        OFF_POST_INCREMENT_WINDOW = 4'h2,                 // post_increment_window
        OFF_PRE_INCREMENT_WINDOW = 4'h3,                  // pre_increment_window
        OFF_INDEXED = 4'h4,                 // indexed_window
        OFF_LOW = 4'h5,                     // data_pointer_low_byte
        OFF_HIGH = 4'h6                     // data_pointer_high_byte
    } reg_off_t;

    // How the pointer is used and modified by one access
    typedef enum logic [2:0] {
        MODE_PLAIN = 3'h0,
        MODE_POST_DECREMENT_WINDOW = 3'h1,
        MODE_POST_INCREMENT_WINDOW = 3'h2,
        MODE_PRE_INCREMENT_WINDOW = 3'h3,
        MODE_INDEXED = 3'h4
    } ptr_mode_t;

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;   // Pointer value after reset
    localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;    // Increment or decrement step
    localparam logic [DATA_W-1:0] ZERO_READ = 8'h00;     // Data of a self-referencing read
    localparam logic [DATA_W-HIGH_W-1:0] HIGH_PAD = 4'h0; // Unimplemented high-byte bits

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // True when the address falls on a pointer slot that exists
    function automatic logic ctrl_hit(input logic [ADDR_W-1:0] addr);
        ctrl_hit = (addr[ADDR_W-1:PAGE_LSB] == CTRL_PAGE) &&
                   (int'(addr[SEL_LSB+SEL_W-1:SEL_LSB]) < NUM_PTR);
    endfunction

    // Pointer number addressed
    function automatic logic [SEL_W-1:0] ctrl_sel(input logic [ADDR_W-1:0] addr);
        ctrl_sel = addr[SEL_LSB+SEL_W-1:SEL_LSB];
    endfunction

    // Register offset within the pointer slot
    function automatic logic [OFF_W-1:0] ctrl_off(input logic [ADDR_W-1:0] addr);
        ctrl_off = addr[OFF_W-1:0];
    endfunction

endpackage

/* rtl/pointer_math_if.sv */
// Carrier between the address unit and its pointer arithmetic
`timescale 1ns/1ps
interface pointer_math_if;
    import indirect_addr_pkg::*;

    logic [ADDR_W-1:0] ptr_cur;      // Pointer value before the access
    ptr_mode_t mode;                 // Access mode picked by the window address
    logic [DATA_W-1:0] offset;       // Signed working register value
    logic [ADDR_W-1:0] access_addr;  // Address actually used for the access
    logic [ADDR_W-1:0] ptr_next;     // Pointer value after the access
    logic ptr_changes;               // Pointer must be rewritten

    modport unit (
        output ptr_cur,
        output mode,
        output offset,
        input access_addr,
        input ptr_next,
        input ptr_changes
    );

    modport math (
        input ptr_cur,
        input mode,
        input offset,
        output access_addr,
        output ptr_next,
        output ptr_changes
    );
endinterface

/* rtl/pointer_math.sv */
// Pointer arithmetic: access address and modified pointer for one access
`timescale 1ns/1ps
module pointer_math
    import indirect_addr_pkg::*;
(
    // Operands and results
    pointer_math_if.math pm
);

    // ------------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] ptr_inc;      // Pointer plus one, full width
    logic [ADDR_W-1:0] ptr_dec;      // Pointer minus one, full width
    logic [ADDR_W-1:0] offset_ext;   // Working register sign-extended
    logic [ADDR_W-1:0] ptr_indexed;  // Pointer plus signed offset

    // Full-width sums carry across bytes and wrap
    assign ptr_inc = pm.ptr_cur + PTR_STEP; // see R12 see R15
    assign ptr_dec = pm.ptr_cur - PTR_STEP; // see R12 see R15
    assign offset_ext = {{HIGH_W{pm.offset[DATA_W-1]}}, pm.offset}; // see R15
    assign ptr_indexed = pm.ptr_cur + offset_ext; // see R10 see R15

    // ------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------
    // Picks the address used now and the value left in the pointer
    always_comb begin
        pm.access_addr = pm.ptr_cur;
        pm.ptr_next = pm.ptr_cur;
        pm.ptr_changes = 1'b0;
        unique case (pm.mode)
            // Pointer left alone
            MODE_PLAIN: begin
                pm.access_addr = pm.ptr_cur; // see R6
            end
            // Use then step down
            MODE_POST_DECREMENT_WINDOW: begin
                pm.access_addr = pm.ptr_cur; // see R7
                pm.ptr_next = ptr_dec;
                pm.ptr_changes = 1'b1;
            end
            // Use then step up
            MODE_POST_INCREMENT_WINDOW: begin
                pm.access_addr = pm.ptr_cur; // see R8
                pm.ptr_next = ptr_inc;
                pm.ptr_changes = 1'b1;
            end
            // Step up then use
            MODE_PRE_INCREMENT_WINDOW: begin
                pm.access_addr = ptr_inc; // see R9
                pm.ptr_next = ptr_inc;
                pm.ptr_changes = 1'b1;
            end
            // Offset by working register, nothing modified
            MODE_INDEXED: begin
                pm.access_addr = ptr_indexed; // see R10
            end
            // Codes 5 to 7 never issued by the unit
            default: begin
                pm.access_addr = pm.ptr_cur;
            end
        endcase
    end

endmodule

/* rtl/indirect_data_address_unit.sv */
// Indirect data-memory address unit with three auto-modifying data pointers
//
// Operation
// R1: Three 12-bit pointers, high and low byte
// R2: Window operand accesses location the pointer holds
// R3: Pointer supplies address; windows store nothing
// R4: Window read via pointer returns zero, sets zero
// R5: Window write via pointer is no-op, flags kept
// R6: Plain window leaves pointer unchanged
// R7: Post-decrement uses pointer, then subtracts one
// R8: Post-increment uses pointer, then adds one
// R9: Pre-increment adds one, then uses pointer
// R10: Indexed adds signed working register, modifies nothing
// R11: Pointer stepping never touches status flags
// R12: Stepping acts on all 12 bits
// R13: Written pointer byte beats auto step
// R14: Decoder may use windows as any operand
// R15: Pointer arithmetic wraps modulo 4096, offset sign-extended
// R16: Upper four high-byte bits unimplemented, read zero
`timescale 1ns/1ps
module indirect_data_address_unit
    import indirect_addr_pkg::*;
#(
    parameter int PTR_COUNT = NUM_PTR      // Number of pointers built
)(
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,

    // Operand request from the execution unit
    input wire logic op_valid_in,
    input wire logic [ADDR_W-1:0] op_addr_in,
    input wire logic op_write_in,
    input wire logic [DATA_W-1:0] op_wdata_in,
    input wire logic [DATA_W-1:0] working_reg_in,

    // Data memory port
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic [DATA_W-1:0] mem_wdata_out,
    input wire logic [DATA_W-1:0] mem_rdata_in,

    // Result to the execution unit
    output logic rd_valid_out,
    output logic [DATA_W-1:0] rd_data_out,
    output logic zero_set_out,
    output logic flags_keep_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Decode serves exactly three pointers
    if (PTR_COUNT != NUM_PTR) begin : g_bad_count
        $error("PTR_COUNT must equal the decoded pointer count");
    end

    // ------------------------------------------------------------------
    // Pointer storage
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] data_pointer_reg [PTR_COUNT]; // Pointers, 12 bits each, see R1

    // ------------------------------------------------------------------
    // Operand decode
    // ------------------------------------------------------------------
    logic op_is_ctrl;                // Operand hits a pointer slot
    logic [SEL_W-1:0] op_sel;        // Pointer named by the operand
    logic [OFF_W-1:0] op_off;        // Offset within that slot
    logic op_is_window;              // Operand is one of the five windows
    logic [SEL_W-1:0] op_sel_safe;   // Select clamped to an existing pointer
    ptr_mode_t op_mode;              // Mode derived from the window offset

    assign op_is_ctrl = ctrl_hit(op_addr_in);
    assign op_sel = ctrl_sel(op_addr_in);
    assign op_off = ctrl_off(op_addr_in);
    assign op_is_window = op_is_ctrl && (op_off <= OFF_INDEXED); // see R2 see R14
    assign op_sel_safe = op_is_ctrl ? op_sel : '0;

    // Window offset picks how the pointer is used
    always_comb begin
        unique case (op_off)
            OFF_POST_DECREMENT_WINDOW: op_mode = MODE_POST_DECREMENT_WINDOW;
            OFF_POST_INCREMENT_WINDOW: op_mode = MODE_POST_INCREMENT_WINDOW;
            OFF_PRE_INCREMENT_WINDOW: op_mode = MODE_PRE_INCREMENT_WINDOW;
            OFF_INDEXED: op_mode = MODE_INDEXED;
            // Plain window and any non-window offset
            default: op_mode = MODE_PLAIN;
        endcase
    end

    // ------------------------------------------------------------------
    // Pointer arithmetic
    // ------------------------------------------------------------------
    pointer_math_if pm_bus ();

    assign pm_bus.ptr_cur = data_pointer_reg[op_sel_safe];
    assign pm_bus.mode = op_mode;
    assign pm_bus.offset = working_reg_in; // Read only, never written back, see R10

    pointer_math math_inst (
        .pm (pm_bus.math)
    );

    // ------------------------------------------------------------------
    // Target decode
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] target_addr;  // Address the access finally reaches
    logic tgt_is_ctrl;               // Target hits a pointer slot
    logic [SEL_W-1:0] tgt_sel;       // Pointer named by the target
    logic [SEL_W-1:0] tgt_sel_safe;  // Target select clamped
    logic [OFF_W-1:0] tgt_off;       // Target offset within slot
    logic tgt_is_window;             // Indirect access lands on a window
    logic tgt_is_low;                // Target is a pointer low byte
    logic tgt_is_high;               // Target is a pointer high byte
    logic [ADDR_W-1:0] tgt_ptr;      // Pointer value named by the target

    // Windows carry no storage; the pointer supplies the address
    assign target_addr = op_is_window ? pm_bus.access_addr : op_addr_in; // see R3
    assign tgt_is_ctrl = ctrl_hit(target_addr);
    assign tgt_sel = ctrl_sel(target_addr);
    assign tgt_sel_safe = tgt_is_ctrl ? tgt_sel : '0;
    assign tgt_off = ctrl_off(target_addr);
    assign tgt_is_window = op_is_window && tgt_is_ctrl && (tgt_off <= OFF_INDEXED);
    assign tgt_is_low = tgt_is_ctrl && (tgt_off == OFF_LOW);
    assign tgt_is_high = tgt_is_ctrl && (tgt_off == OFF_HIGH);
    assign tgt_ptr = data_pointer_reg[tgt_sel_safe];

    // ------------------------------------------------------------------
    // Pointer update, one process per pointer
    // ------------------------------------------------------------------
    generate
        for (genvar n = 0; n < PTR_COUNT; n++) begin : g_ptr
            logic byte_write;        // This pointer's byte is written now
            logic step_here;         // This pointer is auto-modified now

            assign byte_write = op_valid_in && op_write_in &&
                                (tgt_is_low || tgt_is_high) &&
                                (int'(tgt_sel_safe) == n);
            assign step_here = op_valid_in && op_is_window &&
                               (int'(op_sel_safe) == n) && pm_bus.ptr_changes;

            // Written data wins over any step of the same pointer
            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    data_pointer_reg[n] <= PTR_RESET;
                end else if (byte_write) begin
                    // see R13
                    if (tgt_is_low) begin
                        data_pointer_reg[n][DATA_W-1:0] <= op_wdata_in;
                    end else begin
                        // Only four high bits stored, see R16
                        data_pointer_reg[n][ADDR_W-1:DATA_W] <= op_wdata_in[HIGH_W-1:0];
                    end
                end else if (step_here) begin
                    // No flag path exists from the step, see R11 see R12
                    data_pointer_reg[n] <= pm_bus.ptr_next;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Stage 1: memory request and internal result
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] mem_addr_reg;   // Address to data memory
    logic mem_rd_reg;                  // Memory read strobe
    logic mem_wr_reg;                  // Memory write strobe
    logic [DATA_W-1:0] mem_wdata_reg;  // Memory write data
    logic rd_pend_reg;                 // A read result is due next cycle
    logic rd_from_mem_reg;             // Result comes from memory
    logic [DATA_W-1:0] int_data_reg;   // Result served inside the unit
    logic zero_pend_reg;               // Self-referencing read pending
    logic keep_pend_reg;               // Self-referencing write pending
    logic [DATA_W-1:0] ptr_byte_rd;    // Pointer byte as read back
    logic internal_tgt;                // Access does not reach memory

    // High byte reads with unimplemented bits as zero
    assign ptr_byte_rd = tgt_is_high ? {HIGH_PAD, tgt_ptr[ADDR_W-1:DATA_W]} // see R16
                                     : tgt_ptr[DATA_W-1:0];
    assign internal_tgt = tgt_is_window || tgt_is_low || tgt_is_high;

    // Memory strobes, suppressed for targets the unit serves itself
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mem_addr_reg <= PTR_RESET;
            mem_rd_reg <= 1'b0;
            mem_wr_reg <= 1'b0;
            mem_wdata_reg <= ZERO_READ;
        end else begin
            mem_rd_reg <= op_valid_in && !op_write_in && !internal_tgt;
            // Write onto a window is a no-op, see R5
            mem_wr_reg <= op_valid_in && op_write_in && !internal_tgt;
            if (op_valid_in) begin
                mem_addr_reg <= target_addr; // see R2 see R3
                mem_wdata_reg <= op_wdata_in;
            end
        end
    end

    // Read bookkeeping and the internally served data
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_pend_reg <= 1'b0;
            rd_from_mem_reg <= 1'b0;
            int_data_reg <= ZERO_READ;
            zero_pend_reg <= 1'b0;
            keep_pend_reg <= 1'b0;
        end else begin
            rd_pend_reg <= op_valid_in && !op_write_in;
            rd_from_mem_reg <= !internal_tgt;
            // Window read back gives zero and raises zero flag, see R4
            zero_pend_reg <= op_valid_in && !op_write_in && tgt_is_window;
            // Window write keeps every status flag, see R5
            keep_pend_reg <= op_valid_in && op_write_in && tgt_is_window;
            if (op_valid_in) begin
                int_data_reg <= tgt_is_window ? ZERO_READ : ptr_byte_rd;
            end
        end
    end

    // ------------------------------------------------------------------
    // Stage 2: result to the execution unit
    // ------------------------------------------------------------------
    logic rd_valid_reg;              // Result valid pulse
    logic [DATA_W-1:0] rd_data_reg;  // Result data
    logic zero_set_reg;              // Force zero flag pulse
    logic flags_keep_reg;            // Leave flags pulse

    // Memory data is captured in the cycle its strobe stands
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg <= ZERO_READ;
            zero_set_reg <= 1'b0;
            flags_keep_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_pend_reg;
            zero_set_reg <= zero_pend_reg; // see R4
            flags_keep_reg <= keep_pend_reg; // see R5
            if (rd_pend_reg) begin
                rd_data_reg <= rd_from_mem_reg ? mem_rdata_in : int_data_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign mem_addr_out = mem_addr_reg;
    assign mem_rd_out = mem_rd_reg;
    assign mem_wr_out = mem_wr_reg;
    assign mem_wdata_out = mem_wdata_reg;
    assign rd_valid_out = rd_valid_reg;
    assign rd_data_out = rd_data_reg;
    assign zero_set_out = zero_set_reg;
    assign flags_keep_out = flags_keep_reg;

endmodule

/* verification/indirect_data_address_unit_assertions.sv */
// Port-level checker for the indirect data address unit
`timescale 1ns/1ps
module indirect_data_address_unit_checker
    import indirect_addr_pkg::*;
(
    // Clock, reset and request
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic op_valid_in,
    input wire logic [ADDR_W-1:0] op_addr_in,
    input wire logic op_write_in,
    input wire logic [DATA_W-1:0] op_wdata_in,
    // Memory port and result
    input wire logic [ADDR_W-1:0] mem_addr_out,
    input wire logic mem_rd_out,
    input wire logic mem_wr_out,
    input wire logic [DATA_W-1:0] mem_wdata_out,
    input wire logic [DATA_W-1:0] mem_rdata_in,
    input wire logic rd_valid_out,
    input wire logic [DATA_W-1:0] rd_data_out,
    input wire logic zero_set_out,
    input wire logic flags_keep_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);

    strobe_one_kind_a: assert property (!(mem_rd_out && mem_wr_out))
        else $error("read and write strobes together");
    rd_strobe_cause_a: assert property (mem_rd_out |-> $past(op_valid_in && !op_write_in))
        else $error("read strobe without a read request");
    wr_data_cause_a: assert property (mem_wr_out |->
        $past(op_valid_in && op_write_in) && mem_wdata_out == $past(op_wdata_in))
        else $error("write strobe or data wrong");
    rd_result_a: assert property (mem_rd_out |=>
        rd_valid_out && !zero_set_out && rd_data_out == $past(mem_rdata_in))
        else $error("read result not memory data");
    rd_valid_cause_a: assert property (rd_valid_out |-> $past(op_valid_in && !op_write_in, 2))
        else $error("read result without a read request");
    zero_read_a: assert property (zero_set_out |->
        rd_valid_out && rd_data_out == ZERO_READ && $past(!mem_rd_out))
        else $error("window read not zero");
    noop_write_a: assert property (flags_keep_out |->
        !rd_valid_out && $past(!mem_wr_out) && $past(op_valid_in && op_write_in, 2))
        else $error("window write not a no-op");
    post_increment_window_step_a: assert property (
        (op_valid_in && !op_write_in && op_addr_in == 12'hfc2) ##1
        (op_valid_in && !op_write_in && op_addr_in == 12'hfc2 && mem_rd_out &&
         mem_addr_out < 12'hf00) |=> mem_addr_out == $past(mem_addr_out) + 12'h001)
        else $error("post-increment step wrong");
    post_decrement_window_step_a: assert property (
        (op_valid_in && !op_write_in && op_addr_in == 12'hfc1) ##1
        (op_valid_in && !op_write_in && op_addr_in == 12'hfc1 && mem_rd_out &&
         mem_addr_out < 12'hf00) |=> mem_addr_out == $past(mem_addr_out) - 12'h001)
        else $error("post-decrement step wrong");
endmodule

bind indirect_data_address_unit indirect_data_address_unit_checker u_checker (.*);

/* verification/data_memory_model.sv */
// Data memory with asynchronous read, facing the address unit
`timescale 1ns/1ps
module data_memory_model
    import indirect_addr_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Memory port
    input wire logic [ADDR_W-1:0] mem_addr_in,
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    input wire logic [DATA_W-1:0] mem_wdata_in,
    output logic [DATA_W-1:0] mem_rdata_out
);
    logic [DATA_W-1:0] store [0:4095]; // Byte storage, all 4096 places
    logic [DATA_W-1:0] last_reg = 8'h00; // Last value shown on the data lines
    // Seed contents with an address pattern
    initial begin
        for (int i = 0; i < 4096; i++) begin
            store[i] = 8'(i) ^ 8'(i >> 8) ^ 8'ha5;
        end
    end
    // Writes land on the strobe edge
    always @(posedge clk_in) begin
        if (mem_wr_in) begin
            store[mem_addr_in] <= mem_wdata_in;
        end
        last_reg <= mem_rdata_out;
    end
    // Outside a read strobe the lines toggle so stale data never matches
    assign mem_rdata_out = mem_rd_in ? store[mem_addr_in] : ~last_reg;
endmodule

/* verification/indirect_data_address_unit_bench.sv */
// Self-checking bench for the indirect data address unit
`timescale 1ns/1ps
module indirect_data_address_unit_bench
    import indirect_addr_pkg::*;
;
    localparam int K_MEM = 0; // Access reaches memory
    localparam int K_REG = 1; // Pointer byte, no strobe
    localparam int K_ZERO = 2; // Window read through a window
    localparam int K_NOOP = 3; // Window write through a window
    logic clk_in = 1'b0, srst_in = 1'b1, op_valid_in = 1'b0, op_write_in = 1'b0;
    logic [ADDR_W-1:0] op_addr_in = 12'h000, mem_addr_out;
    logic [DATA_W-1:0] op_wdata_in = 8'h00, working_reg_in = 8'h00;
    logic [DATA_W-1:0] mem_wdata_out, mem_rdata_in, rd_data_out;
    logic mem_rd_out, mem_wr_out, rd_valid_out, zero_set_out, flags_keep_out;
    int miscompares = 0;
    int cmp_count = 0;

    indirect_data_address_unit u_dut (.*);
    data_memory_model u_memory (.clk_in, .mem_addr_in(mem_addr_out), .mem_rd_in(mem_rd_out),
        .mem_wr_in(mem_wr_out), .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in));

    // Clock at 8 ns
    initial begin
        forever #4 clk_in = ~clk_in;
    end

    // Untouched memory contents
    function automatic logic [7:0] fm(input logic [11:0] a);
        return a[7:0] ^ {4'h0, a[11:8]} ^ 8'ha5;
    endfunction
    // Address of one register in a pointer slot
    function automatic logic [11:0] win(input int n, input logic [3:0] off);
        return 12'hfc0 | {6'h00, 2'(n), off};
    endfunction

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One request, both answer cycles judged
    task automatic op(input logic [11:0] a, input logic w, input logic [7:0] d,
                      input logic [7:0] working_register, input int kind, input logic [11:0] ea,
                      input logic [7:0] ed);
        op_valid_in = 1'b1;
        op_addr_in = a;
        op_write_in = w;
        op_wdata_in = d;
        working_reg_in = working_register;
        @(negedge clk_in);
        op_valid_in = 1'b0;
        check("read strobe", mem_rd_out, kind == K_MEM && !w);
        check("write strobe", mem_wr_out, kind == K_MEM && w);
        if (kind == K_MEM) check("memory address", mem_addr_out, ea);
        if (kind == K_MEM && w) check("write data", mem_wdata_out, d);
        @(negedge clk_in);
        check("read valid", rd_valid_out, !w);
        if (!w) check("read data", rd_data_out, ed);
        check("zero flag", zero_set_out, kind == K_ZERO);
        check("flags kept", flags_keep_out, kind == K_NOOP);
    endtask

    task automatic set_ptr(input int n, input logic [11:0] v);
        op(win(n, 4'h5), 1'b1, v[7:0], 8'h00, K_REG, 12'h000, 8'h00);
        op(win(n, 4'h6), 1'b1, {4'h0, v[11:8]}, 8'h00, K_REG, 12'h000, 8'h00);
    endtask

    task automatic ptr_is(input int n, input logic [11:0] v);
        op(win(n, 4'h5), 1'b0, 8'h00, 8'h00, K_REG, 12'h000, v[7:0]);
        op(win(n, 4'h6), 1'b0, 8'h00, 8'h00, K_REG, 12'h000, {4'h0, v[11:8]});
    endtask

    // Window operand with a memory read expected
    task automatic rd(input int n, input logic [3:0] off, input logic [7:0] working_register,
                      input logic [11:0] ea);
        op(win(n, off), 1'b0, 8'h00, working_register, K_MEM, ea, fm(ea));
    endtask

    task automatic t_modes();
        set_ptr(0, 12'h0ff);
        rd(0, 4'h0, 8'h00, 12'h0ff);
        rd(0, 4'h0, 8'h00, 12'h0ff);
        rd(0, 4'h2, 8'h00, 12'h0ff);
        ptr_is(0, 12'h100);
        rd(0, 4'h1, 8'h00, 12'h100);
        ptr_is(0, 12'h0ff);
        rd(0, 4'h3, 8'h00, 12'h100);
        rd(0, 4'h4, 8'hff, 12'h0ff);
        rd(0, 4'h4, 8'h7f, 12'h17f);
        rd(0, 4'h4, 8'h80, 12'h080);
        ptr_is(0, 12'h100);
        $display("modes test done");
    endtask

    task automatic t_wrap();
        set_ptr(1, 12'hfff);
        rd(1, 4'h2, 8'h00, 12'hfff);
        ptr_is(1, 12'h000);
        rd(1, 4'h1, 8'h00, 12'h000);
        rd(1, 4'h4, 8'h01, 12'h000);
        op(win(1, 4'h6), 1'b1, 8'hf0, 8'h00, K_REG, 12'h000, 8'h00);
        ptr_is(1, 12'h0ff);
        $display("wrap test done");
    endtask

    task automatic t_write();
        set_ptr(2, 12'h200);
        op(win(2, 4'h2), 1'b1, 8'h3c, 8'h00, K_MEM, 12'h200, 8'h00);
        rd(2, 4'h1, 8'h00, 12'h201);
        op(win(2, 4'h0), 1'b0, 8'h00, 8'h00, K_MEM, 12'h200, 8'h3c);
        $display("write test done");
    endtask

    task automatic t_self();
        set_ptr(0, 12'hfc0);
        op(win(0, 4'h0), 1'b0, 8'h00, 8'h00, K_ZERO, 12'h000, 8'h00);
        op(win(0, 4'h0), 1'b1, 8'h55, 8'h00, K_NOOP, 12'h000, 8'h00);
        set_ptr(0, 12'hfd2);
        op(win(0, 4'h2), 1'b0, 8'h00, 8'h00, K_ZERO, 12'h000, 8'h00);
        ptr_is(0, 12'hfd3);
        ptr_is(1, 12'h0ff);
        set_ptr(0, 12'hfc5);
        op(win(0, 4'h2), 1'b1, 8'h40, 8'h00, K_REG, 12'h000, 8'h00);
        ptr_is(0, 12'hf40);
        $display("self reference test done");
    endtask

    // Back-to-back requests see each other's pointer steps
    task automatic t_b2b();
        logic [11:0] seq [4] = '{12'hfc2, 12'hfc2, 12'hfc1, 12'hfc1};
        set_ptr(0, 12'h0ff);
        foreach (seq[i]) begin
            op_valid_in = 1'b1;
            op_addr_in = seq[i];
            op_write_in = 1'b0;
            @(negedge clk_in);
        end
        op_valid_in = 1'b0;
        repeat (2) @(negedge clk_in);
        ptr_is(0, 12'h0ff);
        $display("back to back test done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(negedge clk_in);
        srst_in = 1'b0;
        for (int n = 0; n < 3; n++) begin
            ptr_is(n, PTR_RESET);
        end
        t_modes();
        t_wrap();
        t_write();
        t_self();
        t_b2b();
        end_of_test();
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        end_of_test();
    end
endmodule
